// ==== hbfm_top.sv ====
// Purpose: Fault management and status clear for an eight-channel half-bridge driver
// Assumes: Fault detector levels and frame decode arrive synchronous to core_clk_in
// Notes:   Frame shifter lives elsewhere; this block sees chip select and decoded bits
// Behaviour
// R1: Clear request clears latched faults and re-enables outputs of the selected group.
// R2: Host resends the previous input pattern with a clear request.
// R3: Clear request acts at chip select rising edge; spacing timer starts then.
// R4: Host waits the spacing interval between two clear requests.
// R5: A fault still present after clear is detected again and may shut down.
// R6: Enable pin toggle or logic power-on reset fully resets the block.
// R7: Driver supply undervoltage forces outputs off, sets supply fail, auto recovers.
// R8: Driver supply undervoltage keeps serial link and programmed values.
// R9: Logic supply undervoltage forces outputs off and clears command and status.
// R10: Overvoltage sets supply fail; outputs off only with lockout enable set.
// R11: Host should keep overvoltage lockout enable set.
// R12: Overcurrent past the channel delay latches both drivers off and sets flag.
// R13: Overcurrent flag and shutdown cleared only by clear request, per group.
// R14: Low-side underload starts one shared timer; later channels wait the remainder.
// R15: Shared underload timer keeps running while underload persists.
// R16: Underload past delay sets flag; latches off only with shutdown enable.
// R17: Group select picks which channels shutdown enable and clear affect.
// R18: Thermal warning follows any sensor over threshold and never changes outputs.
// R19: Thermal shutdown latches the channel off and sets shutdown flag.
// R20: Clear request clears thermal shutdown only after temperature has fallen.
// R21: Status frozen during a frame; refreshed at frame end unless it cleared.
// R22: Eight channels form two groups; group select picks commands and status. Output enable commands here write all eight channels whatever the group select.
// R23: Delay and spacing durations are parameterised cycle counts.
`timescale 1ns/10ps
module hbfm_top #(
    // R23 parameterised durations
    parameter int OC_DELAY_CYC = hbfm_pkg::OC_DELAY_CYC,
    parameter int UL_DELAY_CYC = hbfm_pkg::UL_DELAY_CYC,
    parameter int SRR_GAP_CYC  = hbfm_pkg::SRR_GAP_CYC
) (
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       logic_supply_uv_in,
    input  wire logic       enable_in,
    input  wire logic       chip_select_n_in,
    input  wire logic       status_clear_request_in,
    input  wire logic       channel_group_select_in,
    input  wire logic       overvoltage_lockout_enable_in,
    input  wire logic       underload_shutdown_enable_in,
    input  wire logic [7:0] out_enable_cmd_in,
    input  wire logic       driver_supply_uv_in,
    input  wire logic       driver_supply_ov_in,
    input  wire logic [7:0] high_side_driver_oc_in,
    input  wire logic [7:0] low_side_driver_oc_in,
    input  wire logic [7:0] low_side_driver_ul_in,
    input  wire logic [7:0] temp_warn_in,
    input  wire logic [7:0] temp_shutdown_in,
    output logic [7:0]      drive_enable_out,
    output logic            supply_fail_flag_out,
    output logic [3:0]      overcurrent_flag_out,
    output logic [3:0]      underload_flag_out,
    output logic            thermal_warning_flag_out,
    output logic            thermal_shutdown_flag_out,
    output logic            clear_ready_out
);
    typedef enum logic [1:0] {
        HBFM_IDLE  = 2'b01,
        HBFM_FRAME = 2'b10
    } hbfm_frame_t;

    localparam int CW = hbfm_pkg::CNT_W;

    hbfm_frame_t frame_q;
    logic        cs_n_q;
    logic        en_q;
    logic        frame_end;
    logic        clr_evt;
    logic        full_rst;
    logic [7:0]  grp_mask;
    logic [7:0]  clr_mask;
    logic [7:0]  oc_exp;
    logic [7:0]  oc_lat_q;
    logic [7:0]  ul_lat_q;
    logic [7:0]  ul_off_q;
    logic [7:0]  tsd_lat_q;
    logic [7:0]  ulsd_mask_q;
    logic [7:0]  cmd_q;
    logic [CW-1:0] ul_cnt_q;
    logic [CW-1:0] gap_cnt_q;
    logic        ul_exp;
    logic        lockout;
    logic        stat_hold_q;

    // R6 enable toggle and logic supply reset
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            en_q <= 1'b0;
        end else begin
            en_q <= enable_in;
        end
    end
    // R9 logic supply loss clears everything
    assign full_rst = rst_in || logic_supply_uv_in || !enable_in || !en_q;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cs_n_q <= 1'b1;
        end else begin
            cs_n_q <= chip_select_n_in;
        end
    end
    // R3 act at chip select rising edge
    assign frame_end = chip_select_n_in && !cs_n_q;
    assign clr_evt   = frame_end && status_clear_request_in;

    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            frame_q <= HBFM_IDLE;
        end else begin
            unique case (frame_q)
                HBFM_IDLE: begin
                    if (!chip_select_n_in) begin
                        frame_q <= HBFM_FRAME;
                    end
                end
                HBFM_FRAME: begin
                    if (chip_select_n_in) begin
                        frame_q <= HBFM_IDLE;
                    end
                end
                default: frame_q <= HBFM_IDLE;
            endcase
        end
    end

    // R22 group 0 is channels 0..3, group 1 is 4..7
    assign grp_mask = channel_group_select_in ? 8'hF0 : 8'h0F;
    // R1 R17 clear limited to selected group
    assign clr_mask = clr_evt ? grp_mask : 8'h00;

    // R9 command register cleared by logic supply loss; R8 kept under driver undervoltage
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            cmd_q       <= hbfm_pkg::STAT_RESET;
            ulsd_mask_q <= hbfm_pkg::STAT_RESET;
        end else if (frame_end && !status_clear_request_in) begin
            cmd_q <= out_enable_cmd_in;
            // R17 shutdown enable applies to the selected group
            ulsd_mask_q <= (ulsd_mask_q & ~grp_mask)
                         | (underload_shutdown_enable_in ? grp_mask : 8'h00);
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < hbfm_pkg::NUM_CH; ch++) begin : g_ch
            hbfm_delay #(
                .DELAY_CYC (OC_DELAY_CYC)
            ) u_oc (
                .core_clk_in (core_clk_in),
                .rst_in      (full_rst),
                .fault_in    (high_side_driver_oc_in[ch] || low_side_driver_oc_in[ch]),
                .expired_out (oc_exp[ch])
            );
        end
    endgenerate

    // R14 R15 shared underload timer, free running while any underload stays
    always_ff @(posedge core_clk_in) begin
        if (full_rst || low_side_driver_ul_in == 8'h00) begin
            ul_cnt_q <= '0;
        end else if (ul_cnt_q == CW'(UL_DELAY_CYC)) begin
            ul_cnt_q <= CW'(1);
        end else begin
            ul_cnt_q <= ul_cnt_q + 1'b1;
        end
    end
    assign ul_exp = (ul_cnt_q == CW'(UL_DELAY_CYC));

    // R12 R13 R5 latched overcurrent; set wins over clear
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            oc_lat_q <= hbfm_pkg::LATCH_RESET;
        end else begin
            oc_lat_q <= (oc_lat_q & ~clr_mask) | oc_exp;
        end
    end

    // R16 underload flag, shutdown only when enabled for that channel
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            ul_lat_q <= hbfm_pkg::LATCH_RESET;
            ul_off_q <= hbfm_pkg::LATCH_RESET;
        end else begin
            ul_lat_q <= (ul_lat_q & ~clr_mask)
                      | (ul_exp ? low_side_driver_ul_in : 8'h00);
            ul_off_q <= (ul_off_q & ~clr_mask)
                      | (ul_exp ? (low_side_driver_ul_in & ulsd_mask_q) : 8'h00);
        end
    end

    // R19 R20 thermal shutdown latch; clear only once sensor below hysteresis
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            tsd_lat_q <= hbfm_pkg::LATCH_RESET;
        end else begin
            tsd_lat_q <= (tsd_lat_q & ~(clr_mask & ~temp_shutdown_in)) | temp_shutdown_in;
        end
    end

    // R3 R4 spacing timer; clear_ready_out tells when the host may send again
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            gap_cnt_q <= '0;
        end else if (clr_evt) begin
            gap_cnt_q <= CW'(SRR_GAP_CYC);
        end else if (gap_cnt_q != '0) begin
            gap_cnt_q <= gap_cnt_q - 1'b1;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            clear_ready_out <= 1'b1;
        end else begin
            clear_ready_out <= !clr_evt && (gap_cnt_q <= CW'(1));
        end
    end

    // R7 R10 global lockout, automatic recovery
    assign lockout = driver_supply_uv_in
                  || (driver_supply_ov_in && overvoltage_lockout_enable_in);

    // R18 warning never enters the drive path
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            drive_enable_out <= hbfm_pkg::STAT_RESET;
        end else if (lockout) begin
            drive_enable_out <= 8'h00;
        end else begin
            drive_enable_out <= cmd_q & ~oc_lat_q & ~ul_off_q & ~tsd_lat_q;
        end
    end

    // R21 a clear frame leaves the old status on view until a normal frame ends
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            stat_hold_q <= 1'b0;
        end else if (clr_evt) begin
            stat_hold_q <= 1'b1;
        end else if (frame_end) begin
            stat_hold_q <= 1'b0;
        end
    end

    // R21 status frozen during a frame, refreshed at frame end unless clearing
    always_ff @(posedge core_clk_in) begin
        if (full_rst) begin
            supply_fail_flag_out      <= 1'b0;
            overcurrent_flag_out      <= 4'h0;
            underload_flag_out        <= 4'h0;
            thermal_warning_flag_out  <= 1'b0;
            thermal_shutdown_flag_out <= 1'b0;
        end else if (frame_q == HBFM_IDLE && chip_select_n_in && !clr_evt && !stat_hold_q) begin
            // R7 R10 supply fail follows the supply level
            supply_fail_flag_out      <= driver_supply_uv_in || driver_supply_ov_in;
            overcurrent_flag_out      <= channel_group_select_in ? oc_lat_q[7:4] : oc_lat_q[3:0];
            underload_flag_out        <= channel_group_select_in ? ul_lat_q[7:4] : ul_lat_q[3:0];
            // R18 R19 warning stays set with shutdown
            thermal_warning_flag_out  <= |temp_warn_in || |temp_shutdown_in;
            thermal_shutdown_flag_out <= |tsd_lat_q;
        end
    end

    // R12 overcurrent latches within one cycle of expiry
    oc_latch_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R12
        (oc_exp[1] |=> oc_lat_q[1])) else $error("overcurrent not latched");

    // R13 no clear without request
    oc_hold_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R13
        (oc_lat_q[1] && !clr_evt |=> oc_lat_q[1])) else $error("overcurrent cleared alone");

    sequence s_clr0;
        clr_evt && !channel_group_select_in && !oc_exp[2];
    endsequence
    clr_group_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R1
        (s_clr0 |=> !oc_lat_q[2])) else $error("clear missed group channel");

    clr_other_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R17
        (clr_evt && !channel_group_select_in && oc_lat_q[5] |=> oc_lat_q[5]))
        else $error("clear hit other group");

    uv_off_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R7
        (driver_supply_uv_in |=> drive_enable_out == 8'h00)) else $error("outputs on in undervoltage");

    ov_nolock_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R10
        (driver_supply_ov_in && !overvoltage_lockout_enable_in && !driver_supply_uv_in
         && cmd_q[0] && !oc_lat_q[0] && !ul_off_q[0] && !tsd_lat_q[0]
         |=> drive_enable_out[0])) else $error("overvoltage locked out without enable");

    tsd_off_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R19
        (temp_shutdown_in[3] |=> tsd_lat_q[3] ##1 !drive_enable_out[3]))
        else $error("thermal shutdown did not turn channel off");

    gap_busy_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R3
        (clr_evt |=> !clear_ready_out [*2])) else $error("spacing timer not started");

    status_freeze_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R21
        (frame_q == HBFM_FRAME && !chip_select_n_in |=> $stable(overcurrent_flag_out)))
        else $error("status changed in frame");

    ul_wrap_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R15
        (ul_exp && low_side_driver_ul_in != 8'h00 ##1 low_side_driver_ul_in != 8'h00
         |-> ul_cnt_q == CW'(1))) else $error("underload timer stopped");

    stat_hold_a: assert property (@(posedge core_clk_in) disable iff (full_rst)  // R21
        (stat_hold_q |=> $stable(thermal_shutdown_flag_out)))
        else $error("status changed after clear frame");
endmodule : hbfm_top

// ==== hbfm_pkg.sv ====
// Purpose: Shared constants for the half-bridge fault manager
// Assumes: Eight channels in two groups of four
// Notes:   Delay counts are defaults; the top module exposes them as parameters
package hbfm_pkg;
    localparam int          NUM_CH          = 8;
    localparam int          GRP_CH          = 4;
    localparam int          CLK_PERIOD_NS   = 4;
    // Overcurrent delay, underload delay and clear spacing, in ns
    localparam int          OC_DELAY_NS     = 4000;
    localparam int          UL_DELAY_NS     = 16000;
    localparam int          SRR_GAP_NS      = 8000;
    localparam int          OC_DELAY_CYC    = (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          UL_DELAY_CYC    = (UL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SRR_GAP_CYC     = (SRR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 16;
    localparam logic [7:0]  STAT_RESET      = 8'h00;
    localparam logic [7:0]  LATCH_RESET     = 8'h00;
endpackage : hbfm_pkg

// ==== hbfm_delay.sv ====
// Purpose: Per-channel overcurrent qualification timer
// Assumes: Fault input already synchronous to core_clk_in
// Notes:   Counter restarts whenever the fault input drops
`timescale 1ns/10ps
module hbfm_delay #(
    parameter int DELAY_CYC = 4
) (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic fault_in,
    output logic      expired_out
);
    logic [hbfm_pkg::CNT_W-1:0] cnt_q;

    // R12 overcurrent delay timer
    always_ff @(posedge core_clk_in) begin
        if (rst_in || !fault_in) begin
            cnt_q <= '0;
        end else if (cnt_q != hbfm_pkg::CNT_W'(DELAY_CYC)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign expired_out = fault_in && (cnt_q == hbfm_pkg::CNT_W'(DELAY_CYC));
endmodule : hbfm_delay

// ==== hbfm_host.sv ====
// Purpose: Host model driving the decoded frame bits of the fault manager
// Assumes: Frames last four clocks with at least two idle clocks between them
// Notes:   Clear frames wait for clear_ready; a wait that runs out is counted
`timescale 1ns/10ps
module hbfm_host (
    input  wire logic  core_clk_in,
    input  wire logic  clear_ready_in,
    output logic       chip_select_n_out,
    output logic       clear_req_out,
    output logic       group_sel_out,
    output logic       ul_shut_en_out,
    output logic [7:0] cmd_out
);
    int         timeouts = 0;
    logic [7:0] prev_cmd = 8'h00;
    logic       prev_uls = 1'b0;

    initial begin
        chip_select_n_out = 1'b1;
        clear_req_out = 1'b0;
        group_sel_out = 1'b0;
        ul_shut_en_out = 1'b0;
        cmd_out = 8'h00;
    end

    task automatic send_frame(input logic c, input logic g, input logic [7:0] m, input logic u);
        int n;
        n = 0;
        while (c && clear_ready_in !== 1'b1 && n < 200) begin
            @(posedge core_clk_in);
            n++;
        end
        if (n == 200) timeouts++;
        @(posedge core_clk_in);
        chip_select_n_out <= 1'b0;
        clear_req_out <= c;
        group_sel_out <= g;
        cmd_out <= c ? prev_cmd : m;
        ul_shut_en_out <= c ? prev_uls : u;
        repeat (4) @(posedge core_clk_in);
        chip_select_n_out <= 1'b1;
        @(posedge core_clk_in);
        // Bit is meaningless between frames, so it is not left steady
        clear_req_out <= ~c;
        if (!c) begin
            prev_cmd = m;
            prev_uls = u;
        end
    endtask : send_frame
endmodule : hbfm_host

// ==== testbench.sv ====
// Purpose: Self-checking bench for the half-bridge fault manager
// Assumes: Host model supplies the frame bits; faults are driven here
// Notes:   Short delay counts keep each scenario brief
`timescale 1ns/10ps
module testbench;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       lsuv = 1'b0;
    logic       en = 1'b1;
    logic       overvoltage_lockout_enable = 1'b1;
    logic       dsuv = 1'b0;
    logic       dsov = 1'b0;
    logic [7:0] hs_oc = 8'h00;
    logic [7:0] ls_oc = 8'h00;
    logic [7:0] ul = 8'h00;
    logic [7:0] tw = 8'h00;
    logic [7:0] ts = 8'h00;
    logic       cs_n, clr, grp, uls, crdy, sf, twf, tsdf;
    logic [7:0] cmd, drv;
    logic [3:0] ocf, ulf;
    int         n_errors = 0;
    int         checks_done = 0;

    always #2 clk = ~clk;

    hbfm_top #(.OC_DELAY_CYC(4), .UL_DELAY_CYC(8), .SRR_GAP_CYC(6)) i_hbfm_top (
        .core_clk_in(clk), .rst_in(rst), .logic_supply_uv_in(lsuv), .enable_in(en),
        .chip_select_n_in(cs_n), .status_clear_request_in(clr),
        .channel_group_select_in(grp), .overvoltage_lockout_enable_in(overvoltage_lockout_enable),
        .underload_shutdown_enable_in(uls), .out_enable_cmd_in(cmd),
        .driver_supply_uv_in(dsuv), .driver_supply_ov_in(dsov),
        .high_side_driver_oc_in(hs_oc), .low_side_driver_oc_in(ls_oc),
        .low_side_driver_ul_in(ul), .temp_warn_in(tw), .temp_shutdown_in(ts),
        .drive_enable_out(drv), .supply_fail_flag_out(sf), .overcurrent_flag_out(ocf),
        .underload_flag_out(ulf), .thermal_warning_flag_out(twf),
        .thermal_shutdown_flag_out(tsdf), .clear_ready_out(crdy));

    hbfm_host i_hbfm_host (
        .core_clk_in(clk), .clear_ready_in(crdy), .chip_select_n_out(cs_n),
        .clear_req_out(clr), .group_sel_out(grp), .ul_shut_en_out(uls), .cmd_out(cmd));

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        n_errors += i_hbfm_host.timeouts;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic frame(input logic c, input logic g, input logic [7:0] m, input logic u);
        i_hbfm_host.send_frame(c, g, m, u);
        wt(4);
    endtask : frame

    task automatic sc_overcurrent;
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
        chk("drive", drv, 8'hFF);
        @(posedge clk) begin
            hs_oc <= 8'h22;
            ls_oc <= 8'h04;
        end
        wt(2);
        chk("oc_early", {4'h0, ocf}, 8'h00);
        wt(8);
        chk("oc_flag", {4'h0, ocf}, 8'h06);
        chk("oc_drive", drv, 8'hD9);
        @(posedge clk) hs_oc <= 8'h00;
        // Channel 2 still overloaded, channel 5 outside the group
        frame(1'b1, 1'b0, 8'h00, 1'b0);
        chk("clr_ready", {7'h0, crdy}, 8'h00);
        chk("oc_drive", drv, 8'hDB);
        chk("oc_held", {4'h0, ocf}, 8'h06);
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
        chk("oc_flag", {4'h0, ocf}, 8'h04);
        @(posedge clk) ls_oc <= 8'h00;
        frame(1'b1, 1'b1, 8'h00, 1'b0);
        chk("oc_grp1", drv, 8'hFB);
        frame(1'b1, 1'b0, 8'h00, 1'b0);
        chk("oc_grp0", drv, 8'hFF);
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
        chk("oc_none", {4'h0, ocf}, 8'h00);
    endtask : sc_overcurrent

    task automatic sc_supply;
        @(posedge clk) dsuv <= 1'b1;
        wt(4);
        chk("uv_drive", drv, 8'h00);
        chk("uv_fail", {7'h0, sf}, 8'h01);
        frame(1'b0, 1'b0, 8'h0F, 1'b0);
        @(posedge clk) dsuv <= 1'b0;
        wt(4);
        chk("uv_back", drv, 8'h0F);
        chk("uv_fail", {7'h0, sf}, 8'h00);
        @(posedge clk) begin
            dsov <= 1'b1;
            overvoltage_lockout_enable <= 1'b0;
        end
        wt(4);
        chk("ov_fail", {7'h0, sf}, 8'h01);
        chk("ov_nolock", drv, 8'h0F);
        @(posedge clk) overvoltage_lockout_enable <= 1'b1;
        wt(4);
        chk("ov_lock", drv, 8'h00);
        @(posedge clk) dsov <= 1'b0;
        wt(4);
        chk("ov_back", drv, 8'h0F);
        @(posedge clk) lsuv <= 1'b1;
        wt(3);
        chk("luv_drive", drv, 8'h00);
        @(posedge clk) lsuv <= 1'b0;
        wt(4);
        chk("luv_cmd", drv, 8'h00);
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
        @(posedge clk) en <= 1'b0;
        @(posedge clk) en <= 1'b1;
        wt(4);
        chk("en_reset", drv, 8'h00);
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
    endtask : sc_supply

    task automatic sc_underload;
        frame(1'b0, 1'b1, 8'hFF, 1'b0);
        frame(1'b0, 1'b0, 8'hFF, 1'b1);
        @(posedge clk) ul <= 8'h11;
        wt(5);
        // Channel 1 joins late and only waits out the running timer
        @(posedge clk) ul <= 8'h13;
        wt(6);
        chk("ul_flag", {4'h0, ulf}, 8'h03);
        chk("ul_drive", drv, 8'hFC);
        frame(1'b0, 1'b1, 8'hFF, 1'b0);
        chk("ul_flag1", {4'h0, ulf}, 8'h01);
        chk("ul_drive1", drv, 8'hFC);
        @(posedge clk) ul <= 8'h00;
        frame(1'b1, 1'b1, 8'h00, 1'b0);
        chk("ul_held", {4'h0, ulf}, 8'h01);
        frame(1'b0, 1'b1, 8'hFF, 1'b0);
        chk("ul_clr1", {4'h0, ulf}, 8'h00);
        chk("ul_keep0", drv, 8'hFC);
        frame(1'b1, 1'b0, 8'h00, 1'b0);
        chk("ul_clr0", drv, 8'hFF);
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
        chk("ul_flag0", {4'h0, ulf}, 8'h00);
    endtask : sc_underload

    task automatic sc_thermal;
        @(posedge clk) tw <= 8'h08;
        wt(4);
        chk("tw_flag", {7'h0, twf}, 8'h01);
        chk("tw_drive", drv, 8'hFF);
        @(posedge clk) ts <= 8'h08;
        wt(4);
        chk("tsd_flag", {6'h0, twf, tsdf}, 8'h03);
        chk("tsd_drive", drv, 8'hF7);
        frame(1'b1, 1'b0, 8'h00, 1'b0);
        chk("tsd_hot_drv", drv, 8'hF7);
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
        chk("tsd_hot", {7'h0, tsdf}, 8'h01);
        @(posedge clk) begin
            ts <= 8'h00;
            tw <= 8'h00;
        end
        frame(1'b1, 1'b0, 8'h00, 1'b0);
        chk("tsd_cool_drv", drv, 8'hFF);
        chk("tsd_held", {6'h0, twf, tsdf}, 8'h01);
        frame(1'b0, 1'b0, 8'hFF, 1'b0);
        chk("tsd_cool", {6'h0, twf, tsdf}, 8'h00);
    endtask : sc_thermal

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wt(2);
        chk("rst_drive", drv, 8'h00);
        chk("rst_ready", {7'h0, crdy}, 8'h01);
        sc_overcurrent();
        sc_supply();
        sc_underload();
        sc_thermal();
        report_and_stop();
    end
endmodule : testbench
